// ### pkg/cct_cfg.svh
/*
  Constants for the two-channel capture/compare timer: field positions,
  reset values and prescale taps. Assumes inclusion by bare name.
*/
`ifndef CCT_CFG_SVH
`define CCT_CFG_SVH
`define CCT_CNT_W 16
`define CCT_CNT_RST 16'h0000
`define CCT_MOD_RST 16'hFFFF
`define CCT_VAL_RST 16'h0000
`define CCT_PS_W 3
`define CCT_PS_EXT 3'h7
`define CCT_CTL_W 8
// Channel control field positions
`define CCT_CTL_IE 6
`define CCT_CTL_MSB 5
`define CCT_CTL_MSA 4
`define CCT_CTL_ELSB 3
`define CCT_CTL_ELSA 2
`define CCT_CTL_TOV 1
`define CCT_CTL_MAX 0
`endif

// ### pkg/cct_pkg.sv
/*
  Types for the capture/compare timer. Assumes cct_cfg.svh is available.
*/
package cct_pkg;
  typedef logic [15:0] cct_cnt_t;
  typedef enum logic [1:0] {CCT_ACT_NONE, CCT_ACT_TOGGLE, CCT_ACT_CLEAR, CCT_ACT_SET} cct_act_e;
  typedef enum logic {CCT_SET0, CCT_SET1} cct_bank_e;
endpackage

// ### pkg/cct_chan_if.sv
/*
  Signals between the timer core and one channel unit.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface cct_chan_if;
  logic tick;
  logic ovf;
  logic [15:0] cnt;
  logic [7:0] ctl;
  logic [15:0] cmp_val;
  logic pin_sync;
  logic cap_hit;
  logic cmp_hit;
  logic pin_out;
  modport core (output tick, output ovf, output cnt, output ctl, output cmp_val, output pin_sync,
    input cap_hit, input cmp_hit, input pin_out);
  modport chan (input tick, input ovf, input cnt, input ctl, input cmp_val, input pin_sync,
    output cap_hit, output cmp_hit, output pin_out);
endinterface

// ### logic/cct_chan.sv
/*
  One timer channel: edge detect for capture, compare match and pin action.
  Assumes a synchronised pin level and a counter tick pulse from the core.
*/
`timescale 1ns/1ns
`include "cct_cfg.svh"
module cct_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  cct_chan_if.chan ch
);
  logic pin_prev_ff;
  logic out_ff;
  logic is_cap;
  logic rise;
  logic fall;
  logic hit;
  assign is_cap = ~ch.ctl[`CCT_CTL_MSB] & ~ch.ctl[`CCT_CTL_MSA];
  assign rise = ch.pin_sync & ~pin_prev_ff;
  assign fall = ~ch.pin_sync & pin_prev_ff;
  // Capture edge select: ELSB:ELSA 01 rise, 10 fall, 11 either
  assign ch.cap_hit = is_cap & ((ch.ctl[`CCT_CTL_ELSA] & rise) | (ch.ctl[`CCT_CTL_ELSB] & fall));
  assign hit = ~is_cap & ch.tick & (ch.cnt == ch.cmp_val);
  assign ch.cmp_hit = hit;
  assign ch.pin_out = out_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= ch.pin_sync;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_ff <= 1'b0;
    end else if (!is_cap) begin
      // Overflow toggle wins over a compare in the same cycle; MAX set blocks the compare action
      if (ch.ovf && ch.ctl[`CCT_CTL_TOV]) begin
        out_ff <= ~out_ff;
      end else if (hit && !ch.ctl[`CCT_CTL_MAX]) begin
        unique case ({ch.ctl[`CCT_CTL_ELSB], ch.ctl[`CCT_CTL_ELSA]})
          2'b01: out_ff <= ~out_ff;
          2'b10: out_ff <= 1'b0;
          2'b11: out_ff <= 1'b1;
          2'b00: out_ff <= out_ff;
        endcase
      end
    end
  end
endmodule

// ### logic/cct_timer.sv
/*
  Two-channel capture/compare timer with 16-bit modulo up-counter,
  prescaler, buffered compare link and per-channel flags.
  Assumes software drives plain control ports on the system clock; pins
  and the external clock are asynchronous and synchronised here.
*/
// Functional notes
// - Sixteen-bit up-counter, free-running or modulo.
// - Counter reads never disturb counting.
// - Each channel is capture or compare.
// - Seven bus prescale taps or external clock.
// - Active edge copies counter into channel value.
// - Capture event can request channel interrupt.
// - Compare match sets, clears or toggles pin.
// - Optional pin toggle on every overflow.
// - Separate stop and counter/prescaler reset controls.
// - Unbuffered compare value replaces immediately.
// - Link bit joins channels onto channel 0 pin.
// - Linked: set 0 first, then last written.
// - Linked: channel 0 control governs, pin 1 freed.
// - Overflow flag at modulo; interrupt when enabled.
// - Channel flag per event; interrupt when enabled.
// - Link bit wins over unbuffered bit.
`timescale 1ns/1ns
`include "cct_cfg.svh"
module cct_timer (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic STOP_I,
  input wire logic CNT_RESET_I,
  input wire logic [2:0] PRESCALE_SELECT_I,
  input wire logic OVERFLOW_IRQ_ENABLE_I,
  input wire logic OVERFLOW_FLAG_CLR_I,
  input wire logic [15:0] COUNTER_MODULO_I,
  input wire logic [7:0] CHAN0_CONTROL_I,
  input wire logic [7:0] CHAN1_CONTROL_I,
  input wire logic [1:0] CHAN_FLAG_CLR_I,
  input wire logic [1:0] CHAN_VALUE_WR_I,
  input wire logic [15:0] CHAN_VALUE_WDATA_I,
  input wire logic EXT_TIMER_CLOCK_PIN_I,
  input wire logic CHAN0_PIN_I,
  input wire logic CHAN1_PIN_I,
  output logic [15:0] COUNTER_O,
  output logic [15:0] CHAN0_VALUE_O,
  output logic [15:0] CHAN1_VALUE_O,
  output logic OVERFLOW_FLAG_O,
  output logic [1:0] CHANNEL_EVENT_FLAG_O,
  output logic OVERFLOW_IRQ_O,
  output logic [1:0] CHAN_IRQ_O,
  output logic CHAN0_PIN_O,
  output logic CHAN0_PIN_OE_O,
  output logic CHAN1_PIN_O,
  output logic CHAN1_PIN_OE_O,
  output logic ACTIVE_SET_O
);
  cct_chan_if ch0 ();
  cct_chan_if ch1 ();

  logic [15:0] cnt_ff;
  logic [6:0] pre_ff;
  logic [2:0] ext_sync_ff;
  logic ext_prev_ff;
  logic [2:0] p0_sync_ff;
  logic [2:0] p1_sync_ff;
  logic p0_ff;
  logic p1_ff;
  logic [15:0] val0_ff;
  logic [15:0] val1_ff;
  logic ovf_flag_ff;
  logic [1:0] ch_flag_ff;
  logic ovf_irq_ff;
  logic [1:0] ch_irq_ff;
  logic p0_out_ff;
  logic p0_oe_ff;
  logic p1_out_ff;
  logic p1_oe_ff;
  cct_pkg::cct_bank_e act_ff;
  cct_pkg::cct_bank_e last_wr_ff;
  logic tick;
  logic ovf;
  logic linked;
  logic [7:0] ctl1_eff;
  logic [1:0] ev;

  // Prescaler: tap n ticks once every 2^n bus clocks
  logic [6:0] pre_nxt;
  assign pre_nxt = pre_ff + 7'h01;
  always_comb begin
    tick = 1'b0;
    if (!STOP_I && !CNT_RESET_I) begin
      if (PRESCALE_SELECT_I == `CCT_PS_EXT) begin
        // Third and second stage agree on a rising level
        tick = ext_sync_ff[2] & ext_sync_ff[1] & ~ext_prev_ff;
      end else if (PRESCALE_SELECT_I == 3'h0) begin
        tick = 1'b1;
      end else begin
        tick = (pre_ff & ((7'h01 << PRESCALE_SELECT_I) - 7'h01)) == ((7'h01 << PRESCALE_SELECT_I) - 7'h01);
      end
    end
  end
  assign ovf = tick & (cnt_ff == COUNTER_MODULO_I);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || CNT_RESET_I) begin
      pre_ff <= 7'h00;
    end else if (!STOP_I) begin
      pre_ff <= pre_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ext_sync_ff <= 3'h0;
      ext_prev_ff <= 1'b0;
      p0_sync_ff <= 3'h0;
      p1_sync_ff <= 3'h0;
      p0_ff <= 1'b0;
      p1_ff <= 1'b0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], EXT_TIMER_CLOCK_PIN_I};
      if (ext_sync_ff[2] == ext_sync_ff[1]) ext_prev_ff <= ext_sync_ff[2];
      p0_sync_ff <= {p0_sync_ff[1:0], CHAN0_PIN_I};
      p1_sync_ff <= {p1_sync_ff[1:0], CHAN1_PIN_I};
      if (p0_sync_ff[2] == p0_sync_ff[1]) p0_ff <= p0_sync_ff[2];
      if (p1_sync_ff[2] == p1_sync_ff[1]) p1_ff <= p1_sync_ff[2];
    end
  end

  // Counter register is only read out, so observation cannot disturb it
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || CNT_RESET_I) begin
      cnt_ff <= `CCT_CNT_RST;
    end else if (ovf) begin
      cnt_ff <= `CCT_CNT_RST;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
  assign COUNTER_O = cnt_ff;

  // Link bit alone decides linking, regardless of unbuffered bit
  assign linked = CHAN0_CONTROL_I[`CCT_CTL_MSB];
  assign ctl1_eff = linked ? 8'h00 : CHAN1_CONTROL_I;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      act_ff <= cct_pkg::CCT_SET0;
      last_wr_ff <= cct_pkg::CCT_SET0;
    end else begin
      if (CHAN_VALUE_WR_I[1]) last_wr_ff <= cct_pkg::CCT_SET1;
      else if (CHAN_VALUE_WR_I[0]) last_wr_ff <= cct_pkg::CCT_SET0;
      if (!linked) begin
        act_ff <= cct_pkg::CCT_SET0;
      end else if (ovf) begin
        act_ff <= last_wr_ff;
      end
    end
  end

  assign ch0.tick = tick;
  assign ch0.ovf = ovf;
  assign ch0.cnt = cnt_ff;
  assign ch0.ctl = CHAN0_CONTROL_I;
  assign ch0.cmp_val = (linked && act_ff == cct_pkg::CCT_SET1) ? val1_ff : val0_ff;
  assign ch0.pin_sync = p0_ff;
  assign ch1.tick = tick;
  assign ch1.ovf = ovf;
  assign ch1.cnt = cnt_ff;
  assign ch1.ctl = ctl1_eff;
  assign ch1.cmp_val = val1_ff;
  assign ch1.pin_sync = p1_ff;

  cct_chan u_ch0 (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .ch(ch0)
  );
  cct_chan u_ch1 (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .ch(ch1)
  );

  // Capture wins over a software write in the same cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      val0_ff <= `CCT_VAL_RST;
      val1_ff <= `CCT_VAL_RST;
    end else begin
      if (ch0.cap_hit) val0_ff <= cnt_ff;
      else if (CHAN_VALUE_WR_I[0]) val0_ff <= CHAN_VALUE_WDATA_I;
      if (ch1.cap_hit && !linked) val1_ff <= cnt_ff;
      else if (CHAN_VALUE_WR_I[1]) val1_ff <= CHAN_VALUE_WDATA_I;
    end
  end

  assign ev = {ch1.cap_hit | ch1.cmp_hit, ch0.cap_hit | ch0.cmp_hit};

  // Set wins over clear for every flag
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ovf_flag_ff <= 1'b0;
      ch_flag_ff <= 2'b00;
    end else begin
      ovf_flag_ff <= ovf | (ovf_flag_ff & ~OVERFLOW_FLAG_CLR_I);
      ch_flag_ff <= ev | (ch_flag_ff & ~CHAN_FLAG_CLR_I);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ovf_irq_ff <= 1'b0;
      ch_irq_ff <= 2'b00;
    end else begin
      ovf_irq_ff <= OVERFLOW_IRQ_ENABLE_I & (ovf | (ovf_flag_ff & ~OVERFLOW_FLAG_CLR_I));
      ch_irq_ff[0] <= CHAN0_CONTROL_I[`CCT_CTL_IE] & (ev[0] | (ch_flag_ff[0] & ~CHAN_FLAG_CLR_I[0]));
      ch_irq_ff[1] <= ctl1_eff[`CCT_CTL_IE] & (ev[1] | (ch_flag_ff[1] & ~CHAN_FLAG_CLR_I[1]));
    end
  end

  // Pins drive only in compare mode; channel 1 released when linked
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      p0_out_ff <= 1'b0;
      p0_oe_ff <= 1'b0;
      p1_out_ff <= 1'b0;
      p1_oe_ff <= 1'b0;
    end else begin
      p0_out_ff <= ch0.pin_out;
      p0_oe_ff <= CHAN0_CONTROL_I[`CCT_CTL_MSB] | CHAN0_CONTROL_I[`CCT_CTL_MSA];
      p1_out_ff <= ch1.pin_out;
      p1_oe_ff <= ~linked & (ctl1_eff[`CCT_CTL_MSB] | ctl1_eff[`CCT_CTL_MSA]);
    end
  end

  assign CHAN0_VALUE_O = val0_ff;
  assign CHAN1_VALUE_O = val1_ff;
  assign OVERFLOW_FLAG_O = ovf_flag_ff;
  assign CHANNEL_EVENT_FLAG_O = ch_flag_ff;
  assign OVERFLOW_IRQ_O = ovf_irq_ff;
  assign CHAN_IRQ_O = ch_irq_ff;
  assign CHAN0_PIN_O = p0_out_ff;
  assign CHAN0_PIN_OE_O = p0_oe_ff;
  assign CHAN1_PIN_O = p1_out_ff;
  assign CHAN1_PIN_OE_O = p1_oe_ff;
  assign ACTIVE_SET_O = act_ff;
endmodule

// ### test/cct_timer_props.sv
/* Port checker for cct_timer.
   Assumes it is bound into every cct_timer instance. */
`timescale 1ns/1ns
module cct_timer_props (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic STOP_I,
  input wire logic CNT_RESET_I,
  input wire logic OVERFLOW_IRQ_ENABLE_I,
  input wire logic OVERFLOW_FLAG_CLR_I,
  input wire logic [7:0] CHAN0_CONTROL_I,
  input wire logic [15:0] COUNTER_O,
  input wire logic OVERFLOW_FLAG_O,
  input wire logic [1:0] CHANNEL_EVENT_FLAG_O,
  input wire logic OVERFLOW_IRQ_O,
  input wire logic [1:0] CHAN_IRQ_O,
  input wire logic CHAN1_PIN_OE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  a_count_step: assert property (
    COUNTER_O != $past(COUNTER_O) |-> COUNTER_O == $past(COUNTER_O) + 16'h0001 || COUNTER_O == 16'h0000)
    else $error("counter jumped");
  a_stop_holds: assert property (
    STOP_I && !CNT_RESET_I |=> $stable(COUNTER_O)) else $error("counter moved while stopped");
  a_reset_clears: assert property (
    CNT_RESET_I |=> COUNTER_O == 16'h0000) else $error("counter not cleared");
  a_wrap_flag: assert property (
    $past(COUNTER_O) != 16'h0000 && COUNTER_O == 16'h0000 && !$past(CNT_RESET_I) |-> OVERFLOW_FLAG_O)
    else $error("wrap without overflow flag");
  a_flag_sticky: assert property (
    OVERFLOW_FLAG_O && !OVERFLOW_FLAG_CLR_I |=> OVERFLOW_FLAG_O) else $error("overflow flag lost");
  a_ovf_irq: assert property (
    OVERFLOW_IRQ_O == ($past(OVERFLOW_IRQ_ENABLE_I) && OVERFLOW_FLAG_O)) else $error("overflow request wrong");
  a_chan_irq: assert property (
    CHAN_IRQ_O[0] == ($past(CHAN0_CONTROL_I[6]) && CHANNEL_EVENT_FLAG_O[0])) else $error("channel request wrong");
  a_pin1_freed: assert property (
    CHAN0_CONTROL_I[5] [*4] |-> !CHAN1_PIN_OE_O) else $error("pin 1 driven while linked");
endmodule
bind cct_timer cct_timer_props i_cct_timer_props (.*);

// ### test/test_cct_timer.sv
/* Self-checking bench for cct_timer with an integer counter model.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ns
module test_cct_timer;
  logic clk = '0, rst = '1, stop = '0, crst = '0, oie = '0, oclr = '0, ext = '0, p1 = '0;
  logic [2:0] ps = '0;
  logic [15:0] modv = '1, wd = '0, ev, r, cnt, v0, v1;
  logic [7:0] c0 = '0, c1 = '0;
  logic [1:0] fclr = '0, wr = '0, cf, cirq;
  logic ovf, oirq, act, po0, po1, oe0, oe1, f, g, pe;
  logic [31:0] rs = 32'h0000_0020;
  int bad_count = 0, num_checks = 0, m, n;
  cct_timer i_cct_timer (
    .CLK_SYS_I(clk), .RST_I(rst), .STOP_I(stop), .CNT_RESET_I(crst), .PRESCALE_SELECT_I(ps),
    .OVERFLOW_IRQ_ENABLE_I(oie), .OVERFLOW_FLAG_CLR_I(oclr), .COUNTER_MODULO_I(modv),
    .CHAN0_CONTROL_I(c0), .CHAN1_CONTROL_I(c1), .CHAN_FLAG_CLR_I(fclr), .CHAN_VALUE_WR_I(wr),
    .CHAN_VALUE_WDATA_I(wd), .EXT_TIMER_CLOCK_PIN_I(ext), .CHAN0_PIN_I(p1), .CHAN1_PIN_I(p1),
    .COUNTER_O(cnt), .CHAN0_VALUE_O(v0), .CHAN1_VALUE_O(v1), .OVERFLOW_FLAG_O(ovf),
    .CHANNEL_EVENT_FLAG_O(cf), .OVERFLOW_IRQ_O(oirq), .CHAN_IRQ_O(cirq), .CHAN0_PIN_O(po0),
    .CHAN0_PIN_OE_O(oe0), .CHAN1_PIN_O(po1), .CHAN1_PIN_OE_O(oe1), .ACTIVE_SET_O(act));
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string s);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, s, seen, exp);
    end
  endtask
  // Flag wait or count wait; n holds the cycles taken
  task automatic till(input logic [15:0] v, input logic fl);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((fl ? cf[0] !== 1'h1 : cnt !== v) && n < 3000);
    if (n == 3000) begin
      bad_count++;
      $display("[FAIL] %0t wait ran out", $time);
      summarize();
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(cnt, 16'h0000, "cnt rst");
    chk(16'(ovf), 16'h0000, "flag rst");
    @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    modv <= 16'h0005;
    oie <= 1'h1;
    crst <= 1'h1;
    oclr <= 1'h1;
    @(posedge clk);
    crst <= 1'h0;
    oclr <= 1'h0;
    till(16'h0001, 1'h0);
    m = 1;
    f = 1'h0;
    for (int i = 0; i < 14; i++) begin
      @(negedge clk);
      m = (m == 5) ? 0 : m + 1;
      f = f | (m == 0);
      // Request rises with the flag, gated by the enable of the cycle before
      g = f & oie;
      chk(cnt, m[15:0], "count");
      chk(16'(ovf), 16'(f), "ovf flag");
      chk(16'(oirq), 16'(g), "ovf irq");
    end
    $display("end modulo");
    for (int p = 0; p < 8; p++) begin
      @(posedge clk);
      modv <= 16'hffff;
      ps <= p[2:0];
      crst <= 1'h1;
      @(posedge clk);
      crst <= 1'h0;
      if (p == 7) begin
        // Slow edges so the pin synchroniser sees each one
        repeat (6) begin
          repeat (8) @(posedge clk);
          ext <= ~ext;
        end
        repeat (8) @(negedge clk);
        chk(cnt, 16'h0003, "ext clock");
      end else begin
        till(16'h0001, 1'h0);
        till(16'h0002, 1'h0);
        chk(16'(n), 16'(1 << p), "tap");
      end
    end
    $display("end prescale");
    rs = xs(rs);
    @(posedge clk);
    ps <= 3'h0;
    repeat (rs[5:0] + 1) @(posedge clk);
    stop <= 1'h1;
    repeat (2) @(negedge clk);
    ev = cnt;
    repeat (10) @(negedge clk);
    chk(cnt, ev, "stop");
    @(posedge clk);
    crst <= 1'h1;
    @(posedge clk);
    crst <= 1'h0;
    @(negedge clk);
    chk(cnt, 16'h0000, "cnt reset");
    $display("end stop");
    ev = 16'h0000;
    for (int e = 1; e < 4; e++) begin
      rs = xs(rs);
      @(posedge clk);
      c1 <= 8'h40 | 8'(e << 2);
      c0 <= 8'h40 | 8'(e << 2);
      stop <= 1'h0;
      repeat (rs[5:0] + 2) @(posedge clk);
      stop <= 1'h1;
      repeat (2) @(negedge clk);
      r = cnt;
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        p1 <= ~p1;
        fclr <= 2'h3;
        @(posedge clk);
        fclr <= 2'h0;
        repeat (8) @(negedge clk);
        pe = e[k];
        if (pe) ev = r;
        chk(v1, ev, "cap value");
        chk(v0, ev, "cap value 0");
        chk(16'(cf[1]), 16'(pe), "cap flag");
        chk(16'(cf[0]), 16'(pe), "cap flag 0");
        chk(16'(cirq[1]), 16'(pe), "cap irq");
        chk(16'(oe1), 16'h0000, "cap pin");
      end
    end
    $display("end capture");
    @(posedge clk);
    stop <= 1'h0;
    modv <= 16'h0040;
    crst <= 1'h1;
    c1 <= 8'h00;
    pe = 1'h0;
    // Restart below the new limit so the count never runs past it to the top
    @(posedge clk);
    crst <= 1'h0;
    for (int a = 1; a < 4; a++) begin
      rs = xs(rs);
      // Raising waits for overflow so one period never holds two compares
      if (a > 1 && {10'h000, rs[5:0]} + 16'h0001 > v0) till(16'h0000, 1'h0);
      @(posedge clk);
      c0 <= 8'h50 | 8'(a << 2);
      c1 <= 8'h50 | 8'(a << 2);
      wd <= {10'h000, rs[5:0]} + 16'h0001;
      wr <= 2'h3;
      fclr <= 2'h1;
      @(posedge clk);
      wr <= 2'h0;
      fclr <= 2'h0;
      till(16'h0000, 1'h1);
      repeat (3) @(negedge clk);
      pe = (a == 1) ? ~pe : (a == 3);
      chk(v0, wd, "cmp value");
      chk(16'(po0), 16'(pe), "cmp action");
      chk(16'(oe0), 16'h0001, "cmp drive");
      chk(v1, wd, "cmp value 1");
      chk(16'(po1), 16'(pe), "cmp action 1");
      chk(16'(oe1), 16'h0001, "cmp drive 1");
    end
    $display("end compare");
    @(posedge clk);
    c0 <= 8'h3c;
    wd <= 16'h0010;
    wr <= 2'h2;
    crst <= 1'h1;
    @(posedge clk);
    wr <= 2'h0;
    crst <= 1'h0;
    @(negedge clk);
    chk(16'(act), 16'h0000, "link start");
    till(16'h0000, 1'h0);
    repeat (4) @(negedge clk);
    chk(16'(act), 16'h0001, "link swap");
    chk(16'(oe1), 16'h0000, "link pin");
    $display("end link");
    summarize();
  end
endmodule
